// ---- pkg/osdp_pkg.sv ----
// shared constants for the output-six dependency product logic
package osdp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets (volatile copies)
  localparam logic [7:0] OFS_T1_PRIMARY = 8'h2b;
  localparam logic [7:0] OFS_T1_SECONDARY = 8'h2c;
  localparam logic [7:0] OFS_T1_INPUT_OUTPUT = 8'h2d;
  localparam logic [7:0] OFS_T2_PRIMARY = 8'h2e;
  localparam logic [7:0] OFS_T2_SECONDARY = 8'h2f;
  localparam logic [7:0] OFS_T2_INPUT_OUTPUT = 8'h30;
  localparam logic [7:0] OFS_T1_OUTPUT_EIGHT = 8'h31;
  localparam logic [7:0] OFS_T2_OUTPUT_EIGHT = 8'h3b;
  localparam logic [7:0] OFS_MR_SELECT = 8'h40;

  // page byte of the address: volatile registers and nonvolatile copies
  localparam logic [7:0] PAGE_VOLATILE = 8'h00;
  localparam logic [7:0] PAGE_NONVOLATILE = 8'h80;

  // storage index of each register, shared by registers and copies
  localparam int NUM_REGS = 9;
  localparam logic [3:0] IDX_T1_PRIMARY = 4'h0;
  localparam logic [3:0] IDX_T1_SECONDARY = 4'h1;
  localparam logic [3:0] IDX_T1_INPUT_OUTPUT = 4'h2;
  localparam logic [3:0] IDX_T2_PRIMARY = 4'h3;
  localparam logic [3:0] IDX_T2_SECONDARY = 4'h4;
  localparam logic [3:0] IDX_T2_INPUT_OUTPUT = 4'h5;
  localparam logic [3:0] IDX_T1_OUTPUT_EIGHT = 4'h6;
  localparam logic [3:0] IDX_T2_OUTPUT_EIGHT = 4'h7;
  localparam logic [3:0] IDX_MR_SELECT = 4'h8;
  localparam logic [3:0] IDX_LAST = 4'h8;

  // field positions
  localparam int BIT_T1_OUTPUT_EIGHT = 0;
  localparam int BIT_T2_OUTPUT_EIGHT = 5;
  localparam int BIT_MR_SELECT = 5;

  // reset value of every select register: fully independent
  localparam logic [7:0] RST_SELECT = 8'h00;

  // condition vector layout, mirrors primary/secondary/io register bits
  localparam int COND_W = 26;
  localparam int COND_OUTPUT_EIGHT = 24;
  localparam int COND_MR = 25;
  // usable conditions per variant (five-output variant lacks some)
  localparam logic [COND_W-1:0] VAR_MASK_EIGHT = 26'h3ffffff;
  localparam logic [COND_W-1:0] VAR_MASK_FIVE = 26'h2f3cfcf;

  // other-output index (output number minus one) for io register bits 4..7
  localparam int MAP8_B4 = 2;
  localparam int MAP8_B5 = 3;
  localparam int MAP8_B6 = 4;
  localparam int MAP8_B7 = 6;
  localparam int MAP5_B4 = 0;
  localparam int MAP5_B5 = 1;
  localparam int MAP5_B6 = 2;
  localparam int MAP5_B7 = 4;

  // copy-from-nonvolatile sequencer
  typedef enum logic [2:0] {
    OSDP_IDLE = 3'b001,
    OSDP_LOAD_RD = 3'b010,
    OSDP_LOAD_WR = 3'b100
  } osdp_state_t;

endpackage

// ---- src/osdp_cfg_mem.sv ----
`timescale 1ns/10ps
// nonvolatile copy store: plain array, read data registered
module osdp_cfg_mem
  import osdp_pkg::*;
#(
  parameter int DW = 8,
  parameter int AW = 4,
  parameter int DEPTH = 9
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic re_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);

  logic [DW-1:0] mem [0:DEPTH-1];
  logic [DW-1:0] rdata_reg;

  initial begin
    if (DEPTH > (1 << AW) || DEPTH < 1 || DW < 1) begin
      $error("osdp_cfg_mem: depth does not fit the address width");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // array is not reset: its contents must survive a reset
  always_ff @(posedge clk_sys_i) begin
    if (ce_i && we_i && (int'(waddr_i) < DEPTH)) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // registered read port
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      rdata_reg <= '0;
    end else if (ce_i && re_i) begin
      rdata_reg <= (int'(raddr_i) < DEPTH) ? mem[raddr_i] : '0;
    end
  end

  assign rdata_o = rdata_reg;

endmodule

// ---- src/osdp_term.sv ----
`timescale 1ns/10ps
// one product term: and of non-fault states of selected conditions
module osdp_term
  import osdp_pkg::*;
#(
  parameter int W = 26
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [W-1:0] select_i,
  input wire logic [W-1:0] fault_i,
  output logic term_o
);

  logic term_reg;

  initial begin
    if (W < 1) begin
      $error("osdp_term: width must be at least one");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // and of non-faults
  // unselected bits contribute a one, so a clear select is fully ignored
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      term_reg <= 1'b1;
    end else if (ce_i) begin
      term_reg <= &(~(select_i & fault_i));
    end
  end

  assign term_o = term_reg;

  property p_term_no_select;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      (ce_i && (select_i == '0)) |=> term_o;
  endproperty
  a_term_no_select: assert property (p_term_no_select)
    else $error("term false with nothing selected");

endmodule

// ---- src/osdp_dependency.sv ----
`timescale 1ns/10ps
module osdp_dependency
  import osdp_pkg::*;
#(
  parameter bit EIGHT_OUTPUTS = 1'b1
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic restore_cfg_i,
  input wire logic [5:0] primary_fault_i,
  input wire logic [5:0] secondary_fault_i,
  input wire logic [1:0] watchdog_fault_i,
  input wire logic [3:0] logic_input_fault_i,
  input wire logic [7:0] output_fault_i,
  input wire logic manual_reset_n_i,
  input wire logic [15:0] cfg_addr_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_wdata_i,
  output logic [7:0] cfg_rdata_o,
  output logic cfg_ack_o,
  output logic cfg_err_o,
  output logic busy_o,
  output logic term1_true_o,
  output logic term2_true_o,
  output logic deassert_req_o
);

  localparam int SYNC_W = 27;
  localparam logic [COND_W-1:0] VAR_MASK = EIGHT_OUTPUTS ? VAR_MASK_EIGHT : VAR_MASK_FIVE;
  localparam int B4 = EIGHT_OUTPUTS ? MAP8_B4 : MAP5_B4;
  localparam int B5 = EIGHT_OUTPUTS ? MAP8_B5 : MAP5_B5;
  localparam int B6 = EIGHT_OUTPUTS ? MAP8_B6 : MAP5_B6;
  localparam int B7 = EIGHT_OUTPUTS ? MAP8_B7 : MAP5_B7;
  localparam logic [SYNC_W-1:0] SYNC_RST = {1'b1, {(SYNC_W-1){1'b0}}};

  osdp_state_t state_reg;
  logic [7:0] sel_reg [0:NUM_REGS-1];
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic [COND_W-1:0] cond;
  logic [COND_W-1:0] sel1_vec;
  logic [COND_W-1:0] sel2_vec;
  logic term1, term2, deassert_reg, busy_reg;
  logic [3:0] load_idx_reg;
  logic [7:0] rdata_reg;
  logic ack_reg, err_reg, nv_pend_reg;
  logic [4:0] dec;
  logic dec_valid, page_vol, page_nv, req_ok, mem_we, mem_re;
  logic [3:0] dec_idx;
  logic [3:0] mem_raddr;
  logic [7:0] mem_rdata;
  // all checks below run on the system clock and sleep in reset
  default clocking osdp_cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);

  initial begin
    if (NUM_REGS > 16) begin
      $error("osdp_dependency: register count exceeds index width");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address decode: offset to storage index, bit 4 is the hit flag
  function automatic logic [4:0] osdp_decode(input logic [7:0] ofs);
    logic [4:0] r;
    r = 5'h00;
    if (ofs == OFS_T1_PRIMARY) begin
      r = {1'b1, IDX_T1_PRIMARY};
    end else if (ofs == OFS_T1_SECONDARY) begin
      r = {1'b1, IDX_T1_SECONDARY};
    end else if (ofs == OFS_T1_INPUT_OUTPUT) begin
      r = {1'b1, IDX_T1_INPUT_OUTPUT};
    end else if (ofs == OFS_T2_PRIMARY) begin
      r = {1'b1, IDX_T2_PRIMARY};
    end else if (ofs == OFS_T2_SECONDARY) begin
      r = {1'b1, IDX_T2_SECONDARY};
    end else if (ofs == OFS_T2_INPUT_OUTPUT) begin
      r = {1'b1, IDX_T2_INPUT_OUTPUT};
    end else if (ofs == OFS_T1_OUTPUT_EIGHT) begin
      r = {1'b1, IDX_T1_OUTPUT_EIGHT};
    end else if (ofs == OFS_T2_OUTPUT_EIGHT) begin
      r = {1'b1, IDX_T2_OUTPUT_EIGHT};
    end else if (ofs == OFS_MR_SELECT) begin
      r = {1'b1, IDX_MR_SELECT};
    end
    return r;
  endfunction

  // copy sits 8000h above its register
  // the same low byte addresses a register and its nonvolatile copy
  assign dec = osdp_decode(cfg_addr_i[7:0]);
  assign dec_valid = dec[4];
  assign dec_idx = dec[3:0];
  assign page_vol = (cfg_addr_i[15:8] == PAGE_VOLATILE);
  assign page_nv = (cfg_addr_i[15:8] == PAGE_NONVOLATILE);
  // one request at a time; refused silently while loading or reading a copy
  assign req_ok = ce_i && (state_reg == OSDP_IDLE) && !nv_pend_reg;
  assign mem_we = req_ok && cfg_wr_i && page_nv && dec_valid;
  assign mem_re = (req_ok && cfg_rd_i && !cfg_wr_i && page_nv && dec_valid) || (state_reg == OSDP_LOAD_RD);
  assign mem_raddr = (state_reg == OSDP_IDLE) ? dec_idx : load_idx_reg;

  osdp_cfg_mem #(
    .DW(8),
    .AW(4),
    .DEPTH(NUM_REGS)
  ) u_cfg_mem (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .we_i(mem_we),
    .waddr_i(dec_idx),
    .wdata_i(cfg_wdata_i),
    .re_i(mem_re),
    .raddr_i(mem_raddr),
    .rdata_o(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // restore sequencer: read a copy, then write it into the register
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      state_reg <= OSDP_IDLE;
      load_idx_reg <= 4'h0;
      busy_reg <= 1'b0;
    end else if (ce_i) begin
      case (state_reg)
        OSDP_IDLE: begin
          if (restore_cfg_i && !nv_pend_reg) begin
            state_reg <= OSDP_LOAD_RD;
            load_idx_reg <= 4'h0;
            busy_reg <= 1'b1; // kept beside the state so the port is a flip-flop
          end
        end
        OSDP_LOAD_RD: begin
          state_reg <= OSDP_LOAD_WR;
        end
        OSDP_LOAD_WR: begin
          if (load_idx_reg == IDX_LAST) begin
            state_reg <= OSDP_IDLE;
            busy_reg <= 1'b0;
          end else begin
            state_reg <= OSDP_LOAD_RD;
            load_idx_reg <= load_idx_reg + 4'h1;
          end
        end
        default: begin
          state_reg <= OSDP_IDLE;
          busy_reg <= 1'b0;
        end
      endcase
    end
  end

  // select registers: written by host or by the restore sequence
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        sel_reg[i] <= RST_SELECT;
      end
    end else if (ce_i) begin
      if (state_reg == OSDP_LOAD_WR) begin
        sel_reg[load_idx_reg] <= mem_rdata;
      end else if (req_ok && cfg_wr_i && page_vol && dec_valid) begin
        sel_reg[dec_idx] <= cfg_wdata_i;
      end
    end
  end

  // read data and acknowledge; copy reads take one cycle more
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      rdata_reg <= 8'h00;
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      nv_pend_reg <= 1'b0;
    end else if (ce_i) begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      nv_pend_reg <= 1'b0;
      if (nv_pend_reg) begin
        rdata_reg <= mem_rdata;
        ack_reg <= 1'b1;
      end else if (req_ok && (cfg_wr_i || cfg_rd_i)) begin
        if (!dec_valid || !(page_vol || page_nv)) begin
          // unmapped: answered at once with an error, reads as zero
          ack_reg <= 1'b1;
          err_reg <= 1'b1;
          rdata_reg <= 8'h00;
        end else if (cfg_wr_i) begin
          ack_reg <= 1'b1;
        end else if (page_vol) begin
          rdata_reg <= sel_reg[dec_idx];
          ack_reg <= 1'b1;
        end else begin
          nv_pend_reg <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-stage synchroniser on all monitored conditions
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      sync1_reg <= SYNC_RST;
      sync2_reg <= SYNC_RST;
    end else if (ce_i) begin
      sync1_reg <= {manual_reset_n_i, output_fault_i, logic_input_fault_i, secondary_fault_i,
                    watchdog_fault_i, primary_fault_i};
      sync2_reg <= sync1_reg;
    end
  end

  // condition vector in register-bit order; a set bit means fault
  always_comb begin
    cond[19:0] = sync2_reg[19:0];
    cond[23:20] = {sync2_reg[18+B7], sync2_reg[18+B6], sync2_reg[18+B5], sync2_reg[18+B4]};
    cond[COND_OUTPUT_EIGHT] = sync2_reg[25];
    cond[COND_MR] = !sync2_reg[26];
  end

  // unused conditions masked
  // bits absent on the five-output variant are forced off in case software
  // leaves them set; the stored value still reads back as written
  assign sel1_vec = VAR_MASK & {sel_reg[IDX_MR_SELECT][BIT_MR_SELECT],
                                sel_reg[IDX_T1_OUTPUT_EIGHT][BIT_T1_OUTPUT_EIGHT],
                                sel_reg[IDX_T1_INPUT_OUTPUT], sel_reg[IDX_T1_SECONDARY],
                                sel_reg[IDX_T1_PRIMARY]};
  assign sel2_vec = VAR_MASK & {sel_reg[IDX_MR_SELECT][BIT_MR_SELECT],
                                sel_reg[IDX_T2_OUTPUT_EIGHT][BIT_T2_OUTPUT_EIGHT],
                                sel_reg[IDX_T2_INPUT_OUTPUT], sel_reg[IDX_T2_SECONDARY],
                                sel_reg[IDX_T2_PRIMARY]};

  osdp_term #(
    .W(COND_W)
  ) u_term1 (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .select_i(sel1_vec),
    .fault_i(cond),
    .term_o(term1)
  );

  osdp_term #(
    .W(COND_W)
  ) u_term2 (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .select_i(sel2_vec),
    .fault_i(cond),
    .term_o(term2)
  );

  // single output only
  // the delay timer downstream owns pin timing; this is only its trigger
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      deassert_reg <= 1'b1;
    end else if (ce_i) begin
      deassert_reg <= term1 || term2;
    end
  end

  assign cfg_rdata_o = rdata_reg;
  assign cfg_ack_o = ack_reg;
  assign cfg_err_o = err_reg;
  assign busy_o = busy_reg;
  assign term1_true_o = term1;
  assign term2_true_o = term2;
  assign deassert_req_o = deassert_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks next to the logic
  property p_primary;
    (ce_i && sel1_vec[0] && cond[0]) |=> !term1;
  endproperty
  a_primary: assert property (p_primary)
    else $error("term1 true despite selected primary fault");
  property p_watchdog;
    (ce_i && sel1_vec[7] && cond[7]) |=> !term1;
  endproperty
  a_watchdog: assert property (p_watchdog)
    else $error("term1 true despite selected watchdog fault");
  property p_secondary;
    (ce_i && sel1_vec[8] && cond[8]) |=> !term1;
  endproperty
  a_secondary: assert property (p_secondary)
    else $error("term1 true despite selected secondary fault");
  property p_logic_input;
    (ce_i && sel1_vec[16] && cond[16]) |=> !term1;
  endproperty
  a_logic_input: assert property (p_logic_input)
    else $error("term1 true despite selected logic input three");
  // a faulted neighbour must clear the term through this variant's mapping
  property p_output_map;
    (ce_i && ((sel1_vec[20] && sync2_reg[18+B4]) || (sel1_vec[23] && sync2_reg[18+B7]))) |=> !term1;
  endproperty
  a_output_map: assert property (p_output_map)
    else $error("mapped other output did not clear term1");
  property p_variant;
    !EIGHT_OUTPUTS |-> ((sel1_vec[5:4] == 2'b00) && (sel2_vec[COND_OUTPUT_EIGHT] == 1'b0));
  endproperty
  a_variant: assert property (p_variant)
    else $error("five-output variant uses absent condition");
  // manual reset low reaches both terms, then the request one edge later
  sequence s_mr_low;
    ce_i && sel1_vec[COND_MR] && !sync2_reg[26];
  endsequence
  property p_manual_reset;
    s_mr_low ##1 ce_i |-> (!term1 && !term2) ##1 !deassert_reg;
  endproperty
  a_manual_reset: assert property (p_manual_reset)
    else $error("manual reset low did not hold output asserted");
  property p_either_term;
    ce_i |=> (deassert_reg == ($past(term1) || $past(term2)));
  endproperty
  a_either_term: assert property (p_either_term)
    else $error("deassert request not the or of both terms");
  sequence s_nv_read;
    req_ok && cfg_rd_i && !cfg_wr_i && page_nv && dec_valid;
  endsequence
  property p_nv_read;
    s_nv_read ##1 ce_i |-> !cfg_ack_o ##1 cfg_ack_o;
  endproperty
  a_nv_read: assert property (p_nv_read)
    else $error("copy read not answered on second edge");

endmodule

// ---- verif/osdp_monitor_model.sv ----
`timescale 1ns/10ps
// behavioural monitors, watchdogs and neighbouring outputs seen by the block
module osdp_monitor_model (
  input wire logic [25:0] cond_i,
  input wire logic own_out_i,
  output logic [5:0] primary_fault_o,
  output logic [5:0] secondary_fault_o,
  output logic [1:0] watchdog_fault_o,
  output logic [3:0] logic_input_fault_o,
  output logic [7:0] output_fault_o,
  output logic manual_reset_n_o
);
  ////////////////////////////////////////////////////////////////////////////
  // condition vector follows select bit order, so the bench indexes it once
  assign primary_fault_o = cond_i[5:0];
  assign watchdog_fault_o = cond_i[7:6];
  assign secondary_fault_o = cond_i[13:8];
  assign logic_input_fault_o = cond_i[17:14];
  // neighbours: bit n is output n+1; own output rides on its own line
  assign output_fault_o = {cond_i[24], cond_i[23], own_out_i, cond_i[22:18]};
  // manual reset is an active-low pin
  assign manual_reset_n_o = ~cond_i[25];
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/10ps
module tb;
  import osdp_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic restore = 1'b0;
  logic ce = 1'b1;
  logic five_bus_en = 1'b0;
  logic five_term1;
  logic [25:0] cond = 26'h0;
  logic own_out = 1'b0;
  logic [15:0] cfg_addr = 16'h0;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [7:0] cfg_wdata = 8'h00;
  logic [7:0] cfg_rdata_o;
  logic cfg_ack_o, cfg_err_o, busy_o, term1_true_o, term2_true_o, deassert_req_o;
  logic [5:0] pf, sf;
  logic [1:0] wf;
  logic [3:0] lf;
  logic [7:0] of;
  logic mr_n;
  int errors = 0;
  int samples_checked = 0;
  logic [7:0] ofs [9] = '{8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h30, 8'h31, 8'h3b, 8'h40};

  always #12.5 clk_sys_i = ~clk_sys_i;

  osdp_monitor_model model (.cond_i(cond), .own_out_i(own_out), .primary_fault_o(pf), .secondary_fault_o(sf),
    .watchdog_fault_o(wf), .logic_input_fault_o(lf), .output_fault_o(of), .manual_reset_n_o(mr_n));

  // five-output build only sees the variant scenario
  // its bus is gated so the reserved bits written to the other build never reach it
  osdp_dependency #(.EIGHT_OUTPUTS(1'b0)) dut_five (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(ce),
    .restore_cfg_i(1'b0), .primary_fault_i(pf), .secondary_fault_i(sf), .watchdog_fault_i(wf),
    .logic_input_fault_i(lf), .output_fault_i(of), .manual_reset_n_i(mr_n), .cfg_addr_i(cfg_addr),
    .cfg_wr_i(cfg_wr && five_bus_en), .cfg_rd_i(cfg_rd && five_bus_en), .cfg_wdata_i(cfg_wdata),
    .cfg_rdata_o(), .cfg_ack_o(), .cfg_err_o(), .busy_o(), .term1_true_o(five_term1), .term2_true_o(),
    .deassert_req_o());

  osdp_dependency #(.EIGHT_OUTPUTS(1'b1)) dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(ce),
    .restore_cfg_i(restore), .primary_fault_i(pf), .secondary_fault_i(sf), .watchdog_fault_i(wf),
    .logic_input_fault_i(lf), .output_fault_i(of), .manual_reset_n_i(mr_n), .cfg_addr_i(cfg_addr),
    .cfg_wr_i(cfg_wr), .cfg_rd_i(cfg_rd), .cfg_wdata_i(cfg_wdata), .cfg_rdata_o(cfg_rdata_o),
    .cfg_ack_o(cfg_ack_o), .cfg_err_o(cfg_err_o), .busy_o(busy_o), .term1_true_o(term1_true_o),
    .term2_true_o(term2_true_o), .deassert_req_o(deassert_req_o));

  ////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // one request, dropped after the taking edge; answer sampled at edge
  task automatic acc(input bit w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q,
                     output logic e);
    int n;
    @(posedge clk_sys_i);
    cfg_addr <= a;
    cfg_wr <= w;
    cfg_rd <= !w;
    cfg_wdata <= d;
    @(posedge clk_sys_i);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
    n = 0;
    @(posedge clk_sys_i);
    while (cfg_ack_o !== 1'b1 && n < 4) begin
      @(posedge clk_sys_i);
      n++;
    end
    chk({7'h0, cfg_ack_o}, 8'h01, "no answer");
    q = cfg_rdata_o;
    e = cfg_err_o;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic e;
    acc(1'b1, a, d, q, e);
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp, input logic err_exp);
    logic [7:0] q;
    logic e;
    acc(1'b0, a, 8'h00, q, e);
    chk(q, exp, "read data");
    chk({7'h0, e}, {7'h0, err_exp}, "error flag");
  endtask

  // conditions reach the request output within four edges
  task automatic set_cond(input logic [25:0] c, input logic o);
    @(posedge clk_sys_i);
    cond <= c;
    own_out <= o;
    repeat (5) @(posedge clk_sys_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs();
    for (int i = 0; i < 9; i++) begin
      rd_chk({8'h00, ofs[i]}, RST_SELECT, 1'b0);
      wr({8'h00, ofs[i]}, 8'ha5 ^ 8'(i));
      rd_chk({8'h00, ofs[i]}, 8'ha5 ^ 8'(i), 1'b0);
      wr({8'h00, ofs[i]}, 8'h00);
    end
    // unmapped place answers with error and zero data
    rd_chk(16'h0041, 8'h00, 1'b1);
  endtask

  // walk select bits 0 to 24 of one term (all but manual reset), others all faulted
  task automatic t_term(input bit t2);
    logic [7:0] r;
    int b;
    for (int k = 0; k < 25; k++) begin
      r = (k == 24) ? (t2 ? 8'h3b : 8'h31) : ofs[(t2 ? 3 : 0) + k / 8];
      b = (k == 24) ? (t2 ? 5 : 0) : k % 8;
      wr({8'h00, r}, 8'h01 << b);
      set_cond(~(26'h1 << k), 1'b1);
      chk({7'h0, t2 ? term2_true_o : term1_true_o}, 8'h01, "unselected cond seen");
      set_cond(26'h1 << k, 1'b0);
      chk({7'h0, t2 ? term2_true_o : term1_true_o}, 8'h00, "selected cond lost");
      chk({7'h0, t2 ? term1_true_o : term2_true_o}, 8'h01, "other term touched");
      wr({8'h00, r}, 8'h00);
    end
    set_cond(26'h0, 1'b0);
  endtask

  task automatic t_manual();
    wr(16'h0040, 8'h20);
    set_cond(26'h2000000, 1'b0);
    chk({5'h0, term1_true_o, term2_true_o, deassert_req_o}, 8'h00, "manual reset ignored");
    set_cond(26'h0, 1'b0);
    chk({7'h0, deassert_req_o}, 8'h01, "manual reset release");
    wr(16'h0040, 8'hdf);
    set_cond(26'h2000000, 1'b0);
    chk({7'h0, term1_true_o}, 8'h01, "manual reset not ignored");
    wr(16'h0040, 8'h00);
    set_cond(26'h0, 1'b0);
  endtask

  task automatic t_either();
    wr(16'h002b, 8'h01);
    wr(16'h002e, 8'h02);
    set_cond(26'h1, 1'b0);
    chk({6'h0, term1_true_o, deassert_req_o}, 8'h01, "term2 alone");
    set_cond(26'h3, 1'b0);
    chk({7'h0, deassert_req_o}, 8'h00, "neither term");
    set_cond(26'h2, 1'b0);
    chk({6'h0, term2_true_o, deassert_req_o}, 8'h01, "term1 alone");
    wr(16'h002b, 8'h00);
    wr(16'h002e, 8'h00);
    set_cond(26'h0, 1'b0);
  endtask

  // nonvolatile copies sit 8000h above, restored in one sweep
  task automatic t_restore();
    int n;
    for (int i = 0; i < 9; i++) begin
      wr({8'h80, ofs[i]}, 8'h11 * 8'(i + 1));
    end
    rd_chk(16'h802d, 8'h33, 1'b0);
    @(posedge clk_sys_i);
    restore <= 1'b1;
    @(posedge clk_sys_i);
    restore <= 1'b0;
    @(posedge clk_sys_i);
    chk({7'h0, busy_o}, 8'h01, "busy missing");
    n = 0;
    while (busy_o !== 1'b0 && n < 30) begin
      @(posedge clk_sys_i);
      n++;
    end
    chk(8'(n), 8'h12, "busy length");
    for (int i = 0; i < 9; i++) begin
      rd_chk({8'h00, ofs[i]}, 8'h11 * 8'(i + 1), 1'b0);
    end
  endtask

  // clock enable low freezes synchronisers and terms until it returns
  task automatic t_freeze();
    wr(16'h002b, 8'h01);
    @(posedge clk_sys_i);
    ce <= 1'b0;
    set_cond(26'h1, 1'b0);
    chk({7'h0, term1_true_o}, 8'h01, "term moved while frozen");
    ce <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    chk({7'h0, term1_true_o}, 8'h00, "term stuck after freeze");
    wr(16'h002b, 8'h00);
    set_cond(26'h0, 1'b0);
  endtask

  // 2Dh bit 4 means output three on the eight-output build, output one on the five
  task automatic t_variant();
    five_bus_en <= 1'b1;
    wr(16'h002d, 8'h10);
    set_cond(26'h40000, 1'b0);
    chk({6'h0, term1_true_o, five_term1}, 8'h02, "output one mapping");
    set_cond(26'h100000, 1'b0);
    chk({6'h0, term1_true_o, five_term1}, 8'h01, "output three mapping");
    wr(16'h002d, 8'h00);
    five_bus_en <= 1'b0;
    set_cond(26'h0, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // run control
  task automatic stop_test();
    if (errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // whole run takes about 1200 cycles; generous margin
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    errors++;
    $display("unexpected at %0t: run hung", $time);
    stop_test();
  end

  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    t_regs();
    // reserved variant bits are only written on the eight-output build
    t_term(1'b0);
    t_term(1'b1);
    t_manual();
    t_either();
    t_freeze();
    t_variant();
    t_restore();
    stop_test();
  end
endmodule
